//--- shared/ssc_params.svh
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH
`define SSC_CLK_NS          10
`define SSC_TICK_NS         1000000000
`define SSC_START_S         14'h0001
`define SSC_PUMP_LEAD_S     14'h0003
`define SSC_PUMP_HOLD_MAX_S 14'h003c
`define SSC_TIME_MAX        14'h270f
`define SSC_TIME_MIN        14'h0001
`define SSC_COUNT_MIN       14'h0002
`define SSC_HOLD_MIN        14'h0000
`define SSC_LIMIT_MAX       24'h98967f
`define SSC_MODE_SINGLE     2'h0
`define SSC_MODE_REPEAT     2'h1
`define SSC_MODE_COUNTED    2'h2
`define SSC_UNIT_TOTAL      2'h0
`define SSC_UNIT_LITER      2'h1
`define SSC_UNIT_CFT        2'h2
`define SSC_UNIT_CM         2'h3
`define SSC_L_NUM           36'h258
`define SSC_L_DEN           36'h11b
`define SSC_CF_NUM          36'h03c
`define SSC_M3_NUM          36'h847
`define SSC_FMT_NONE        2'h0
`define SSC_FMT_CSV         2'h1
`define SSC_FMT_PRN         2'h2
`define SSC_LINE_RS232      2'h0
`define SSC_LINE_RS485      2'h1
`define SSC_LINE_NET        2'h2
`define SSC_ST_STOPPED      2'h0
`define SSC_ST_STARTING     2'h1
`define SSC_ST_COUNTING     2'h2
`define SSC_ST_HOLDING      2'h3
`define SSC_CSV_SEP         8'h2c
`define SSC_PRN_SEP         8'h0d
`define SSC_CH_N            6
`define SSC_FAV_N           2
`define SSC_LAST_BYTE       3'h4
`define SSC_FIFO_W          8
`define SSC_FIFO_D          16
`define SSC_BAUD_N          10
`define SSC_BAUD_LAST       4'h9
`define SSC_BAUD_TABLE      '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200}
`define SSC_FRAME_BITS      4'ha
`endif

//--- shared/ssc_pkg.sv
package ssc_pkg;
  typedef enum logic [1:0] {SEQ_STOPPED, SEQ_STARTING, SEQ_COUNTING, SEQ_HOLDING} ssc_seq_e;
  typedef enum logic [1:0] {REP_IDLE, REP_SER, REP_PRN} ssc_rep_e;
  typedef logic [23:0] ssc_cnt_t;
  typedef logic [13:0] ssc_sec_t;
endpackage

//--- core/ssc_top.sv
`timescale 1ns/1ns
// Function
// - Single mode runs one sample after start, then stops, no hold.
// - Repeat mode alternates sample and hold until the operator stops it.
// - Counted mode takes 2 to 9999 samples with holds, then stops.
// - Counts accumulate only during the sample, 1 to 9999 seconds, pump running.
// - Repeat and counted modes time a 0 to 9999 second hold between samples.
// - Hold of 60 seconds or less keeps the pump running throughout.
// - Longer hold stops the pump, restarting it a few seconds before sampling.
// - Counts shown in one selected unit, updated at the end of each sample.
// - Serial report format none, comma-separated or printer; none sends nothing.
// - Comma-separated report always carries all six channels.
// - Printer enable gates panel printout, which always uses printer layout.
// - Serial bit rate selectable from 300 to 115200 baud.
// - Line mode RS232, RS485 or network; network sends only when addressed.
// - Flow control none or RTS/CTS; host must match rate and flow control.
// - Favourites pick two of six channels for display, print and alarm.
// - Favourite alarm asserts when its count reaches or exceeds its limit.
// - A zero alarm limit disables that favourite's alarm.
// - Alarm limit holds at most 9,999,999; larger values are clamped.
// - Alarm compares the raw limit with the count in the current unit.
// - Confirm commits an edited setting; cancel restores the previous value.
// - A set password blocks the settings menu until entered correctly.
// - Status reports starting, counting with seconds left, holding with seconds left.
// - One start/stop command starts when stopped and stops when running.
// - Each sample end emits a serial report in the selected format, except with format none or an unaddressed network line.
`include "ssc_params.svh"

module ssc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW:0]  wr_ff;
  logic [AW:0]  rd_ff;
  wire          full_w  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire          empty_w = (wr_ff == rd_ff);
  wire          push_w  = in_valid_i && !full_w;
  wire          pop_w   = out_ready_i && !empty_w;
  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else if (ce_i) begin
      if (push_w) begin
        mem_ff[wr_ff[AW-1:0]] <= in_data_i;
        wr_ff                 <= wr_ff + 1'b1;
      end
      if (pop_w) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule // ssc_fifo

module ssc_top import ssc_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `SSC_TICK_NS / `SSC_CLK_NS
) (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 ce_i,
  input  wire logic                 start_stop_i,
  input  wire logic [`SSC_CH_N-1:0] particle_i,
  input  wire logic [1:0]           sample_mode_i,
  input  wire logic [13:0]          sample_count_i,
  input  wire logic [13:0]          sample_time_i,
  input  wire logic [13:0]          hold_time_i,
  input  wire logic [1:0]           unit_sel_i,
  input  wire logic [1:0]           report_fmt_i,
  input  wire logic                 printer_en_i,
  input  wire logic [3:0]           baud_sel_i,
  input  wire logic [1:0]           line_mode_i,
  input  wire logic                 addressed_i,
  input  wire logic                 flow_ctl_i,
  input  wire logic                 cts_n_i,
  input  wire logic                 fav_en_i,
  input  wire logic [2:0]           fav_sel0_i,
  input  wire logic [2:0]           fav_sel1_i,
  input  wire logic                 edit_open_i,
  input  wire logic                 edit_tgt_i,
  input  wire logic                 edit_wr_i,
  input  wire logic [23:0]          edit_val_i,
  input  wire logic                 confirm_i,
  input  wire logic                 cancel_edit_key_i,
  input  wire logic [13:0]          password_i,
  input  wire logic                 pwd_try_i,
  input  wire logic [13:0]          pwd_val_i,
  input  wire logic                 menu_exit_i,
  input  wire logic                 prn_ready_i,
  output logic                      menu_access_o,
  output logic [23:0]               edit_shown_o,
  output logic [23:0]               alarm_limit0_o,
  output logic [23:0]               alarm_limit1_o,
  output logic [1:0]                alarm_o,
  output logic [1:0]                status_o,
  output logic [13:0]               remain_s_o,
  output logic                      pump_on_o,
  output logic [23:0]               fav_val0_o,
  output logic [23:0]               fav_val1_o,
  output logic                      tx_o,
  output logic                      de_o,
  output logic                      rts_n_o,
  output logic                      prn_valid_o,
  output logic [7:0]                prn_data_o
);
  localparam int unsigned CLK_HZ = `SSC_TICK_NS / `SSC_CLK_NS;
  localparam int unsigned BAUD_RATES [`SSC_BAUD_N] = `SSC_BAUD_TABLE;

  function automatic ssc_sec_t clamp_sec(input ssc_sec_t v, input ssc_sec_t lo);
    clamp_sec = (v < lo) ? lo : ((v > `SSC_TIME_MAX) ? `SSC_TIME_MAX : v);
  endfunction

  function automatic logic [2:0] fav_idx(input logic [2:0] s);
    fav_idx = (s > 3'(`SSC_CH_N - 1)) ? 3'(`SSC_CH_N - 1) : s;
  endfunction

  // Concentrations assume the nominal one cubic foot per minute flow.
  function automatic ssc_cnt_t conv(input ssc_cnt_t c, input logic [1:0] u, input ssc_sec_t el);
    logic [35:0] num;
    logic [35:0] den;
    logic [35:0] q;
    den = (el == '0) ? 36'h1 : 36'(el);
    case (u)
      `SSC_UNIT_TOTAL: begin num = 36'(c); den = 36'h1; end
      `SSC_UNIT_LITER: begin num = 36'(c) * `SSC_L_NUM; den = den * `SSC_L_DEN; end
      `SSC_UNIT_CFT:   num = 36'(c) * `SSC_CF_NUM;
      default:         num = 36'(c) * `SSC_M3_NUM;
    endcase
    q    = num / den;
    conv = (q[35:24] != '0) ? '1 : q[23:0];
  endfunction

  // Pin inputs: three stages, a change counts once stages two and three agree.
  localparam int NPIN = `SSC_CH_N + 2;
  wire  [NPIN-1:0] pin_raw = {cts_n_i, start_stop_i, particle_i};
  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff, stab_ff, stab_d_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      s3_ff     <= '0;
      stab_ff   <= '0;
      stab_d_ff <= '0;
    end else if (ce_i) begin
      s1_ff     <= pin_raw;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      stab_ff   <= (s2_ff & s3_ff) | (stab_ff & (s2_ff ^ s3_ff));
      stab_d_ff <= stab_ff;
    end
  end
  wire [NPIN-1:0] rise_w = stab_ff & ~stab_d_ff;
  wire            ss_evt = rise_w[`SSC_CH_N];
  wire            cts_ok = !stab_ff[`SSC_CH_N+1];

  // Sequencer.
  ssc_seq_e     seq_ff, nxt_seq;
  ssc_sec_t     remain_ff, nxt_remain, done_ff, nxt_done;
  ssc_sec_t     stime_ff, hold_ff, ncount_ff, el_ff;
  logic [1:0]   mode_ff;
  logic [31:0]  tick_cnt_ff;
  logic         pump_ff, nxt_pump, sample_end, start_samp;
  wire          tick = (tick_cnt_ff == TICK_CYCLES - 1);
  wire          long_hold = hold_ff > `SSC_PUMP_HOLD_MAX_S;
  wire          last_sec = tick && (remain_ff == 14'h1);
  wire          run_done = (mode_ff == `SSC_MODE_SINGLE) ||
                           ((mode_ff == `SSC_MODE_COUNTED) && (done_ff + 14'h1 >= ncount_ff));

  always_comb begin
    nxt_seq    = seq_ff;
    nxt_remain = remain_ff;
    nxt_done   = done_ff;
    sample_end = 1'b0;
    start_samp = 1'b0;
    case (seq_ff)
      SEQ_STOPPED: if (ss_evt) begin
        nxt_seq    = SEQ_STARTING;
        nxt_remain = `SSC_START_S;
        nxt_done   = '0;
      end
      SEQ_STARTING: begin
        if (ss_evt) nxt_seq = SEQ_STOPPED;
        else if (last_sec) begin
          nxt_seq    = SEQ_COUNTING;
          nxt_remain = stime_ff;
          start_samp = 1'b1;
        end else if (tick) nxt_remain = remain_ff - 14'h1;
      end
      SEQ_COUNTING: begin
        if (ss_evt) nxt_seq = SEQ_STOPPED;
        else if (last_sec) begin
          sample_end = 1'b1;
          nxt_done   = done_ff + 14'h1;
          if (run_done) nxt_seq = SEQ_STOPPED;
          else if (hold_ff == '0) begin
            nxt_remain = stime_ff;
            start_samp = 1'b1;
          end else begin
            nxt_seq    = SEQ_HOLDING;
            nxt_remain = hold_ff;
          end
        end else if (tick) nxt_remain = remain_ff - 14'h1;
      end
      SEQ_HOLDING: begin
        if (ss_evt) nxt_seq = SEQ_STOPPED;
        else if (last_sec) begin
          nxt_seq    = SEQ_COUNTING;
          nxt_remain = stime_ff;
          start_samp = 1'b1;
        end else if (tick) nxt_remain = remain_ff - 14'h1;
      end
      default: nxt_seq = SEQ_STOPPED;
    endcase
    case (nxt_seq)
      SEQ_STARTING, SEQ_COUNTING: nxt_pump = 1'b1;
      SEQ_HOLDING: nxt_pump = !long_hold || (nxt_remain <= `SSC_PUMP_LEAD_S);
      default:     nxt_pump = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      seq_ff      <= SEQ_STOPPED;
      remain_ff   <= '0;
      done_ff     <= '0;
      pump_ff     <= 1'b0;
      tick_cnt_ff <= '0;
      stime_ff    <= `SSC_TIME_MIN;
      hold_ff     <= `SSC_HOLD_MIN;
      ncount_ff   <= `SSC_COUNT_MIN;
      mode_ff     <= `SSC_MODE_SINGLE;
      el_ff       <= '0;
    end else if (ce_i) begin
      seq_ff      <= nxt_seq;
      remain_ff   <= nxt_remain;
      done_ff     <= nxt_done;
      pump_ff     <= nxt_pump;
      tick_cnt_ff <= (seq_ff == SEQ_STOPPED || tick) ? '0 : tick_cnt_ff + 32'h1;
      if (seq_ff == SEQ_STOPPED && ss_evt) begin
        stime_ff  <= clamp_sec(sample_time_i, `SSC_TIME_MIN);
        hold_ff   <= clamp_sec(hold_time_i, `SSC_HOLD_MIN);
        ncount_ff <= clamp_sec(sample_count_i, `SSC_COUNT_MIN);
        mode_ff   <= sample_mode_i;
      end
      if (start_samp) el_ff <= '0;
      else if (tick && seq_ff == SEQ_COUNTING) el_ff <= el_ff + 14'h1;
    end
  end
  assign pump_on_o  = pump_ff;
  assign remain_s_o = remain_ff;

  logic [1:0] status_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) status_ff <= `SSC_ST_STOPPED;
    else if (ce_i) begin
      case (nxt_seq)
        SEQ_STARTING: status_ff <= `SSC_ST_STARTING;
        SEQ_COUNTING: status_ff <= `SSC_ST_COUNTING;
        SEQ_HOLDING:  status_ff <= `SSC_ST_HOLDING;
        default:      status_ff <= `SSC_ST_STOPPED;
      endcase
    end
  end
  assign status_o = status_ff;

  // Channel counters and live values in the chosen unit.
  ssc_cnt_t cnt_ff [`SSC_CH_N];
  ssc_cnt_t val_w  [`SSC_CH_N];
  ssc_cnt_t snap_ff[`SSC_CH_N];
  genvar g;
  generate
    for (g = 0; g < `SSC_CH_N; g++) begin : g_ch
      assign val_w[g] = conv(cnt_ff[g], unit_sel_i, el_ff);
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          cnt_ff[g]  <= '0;
          snap_ff[g] <= '0;
        end else if (ce_i) begin
          if (start_samp) cnt_ff[g] <= '0;
          else if (seq_ff == SEQ_COUNTING && rise_w[g] && cnt_ff[g] != '1)
            cnt_ff[g] <= cnt_ff[g] + 24'h1;
          if (sample_end) snap_ff[g] <= val_w[g];
        end
      end
    end
  endgenerate

  // Favourites, alarm limits, editing and password.
  wire [2:0] fav0 = fav_idx(fav_sel0_i);
  wire [2:0] fav1 = fav_idx(fav_sel1_i);
  ssc_cnt_t  limit_ff [`SSC_FAV_N];
  ssc_cnt_t  work_ff;
  logic [1:0] alarm_ff;
  logic      unlock_ff;
  logic      editing_ff;
  logic      tgt_ff;
  wire       pwd_set = (password_i != '0);
  assign menu_access_o = !pwd_set || unlock_ff;
  wire       can_edit = menu_access_o && editing_ff;
  wire [23:0] clamped = (edit_val_i > `SSC_LIMIT_MAX) ? `SSC_LIMIT_MAX : edit_val_i;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      limit_ff[0] <= '0;
      limit_ff[1] <= '0;
      work_ff     <= '0;
      alarm_ff    <= '0;
      unlock_ff   <= 1'b0;
      editing_ff  <= 1'b0;
      tgt_ff      <= 1'b0;
    end else if (ce_i) begin
      if (pwd_try_i && pwd_val_i == password_i) unlock_ff <= 1'b1;
      else if (menu_exit_i) unlock_ff <= 1'b0;
      if (menu_access_o && edit_open_i) begin
        editing_ff <= 1'b1;
        tgt_ff     <= edit_tgt_i;
        work_ff    <= limit_ff[edit_tgt_i];
      end else if (can_edit && cancel_edit_key_i) begin
        editing_ff <= 1'b0;
        work_ff    <= limit_ff[tgt_ff];
      end else if (can_edit && confirm_i) begin
        editing_ff       <= 1'b0;
        limit_ff[tgt_ff] <= work_ff;
      end else if (can_edit && edit_wr_i) work_ff <= clamped;
      alarm_ff[0] <= fav_en_i && limit_ff[0] != '0 && val_w[fav0] >= limit_ff[0];
      alarm_ff[1] <= fav_en_i && limit_ff[1] != '0 && val_w[fav1] >= limit_ff[1];
    end
  end
  assign edit_shown_o   = work_ff;
  assign alarm_limit0_o = limit_ff[0];
  assign alarm_limit1_o = limit_ff[1];
  assign alarm_o        = alarm_ff;
  assign fav_val0_o     = snap_ff[fav0];
  assign fav_val1_o     = snap_ff[fav1];

  // Report generator: serial pass into the FIFO, then printer pass.
  ssc_rep_e   rep_ff;
  logic [2:0] pos_ff, bi_ff;
  logic       prn_valid_ff;
  logic [7:0] prn_data_ff;
  logic       fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out;
  wire  ser_en  = (report_fmt_i != `SSC_FMT_NONE) &&
                  (line_mode_i != `SSC_LINE_NET || addressed_i);
  wire  prn_lay = (rep_ff == REP_PRN) || (report_fmt_i == `SSC_FMT_PRN);
  wire  two_ch  = prn_lay && fav_en_i;
  wire [2:0] n_last = two_ch ? 3'(`SSC_FAV_N - 1) : 3'(`SSC_CH_N - 1);
  wire [2:0] chan   = two_ch ? ((pos_ff == '0) ? fav0 : fav1) : pos_ff;
  wire [7:0] sep    = prn_lay ? `SSC_PRN_SEP : `SSC_CSV_SEP;
  wire [7:0] cur_byte = (bi_ff == 3'h0) ? {5'h0, chan} :
                        (bi_ff == 3'h1) ? snap_ff[chan][23:16] :
                        (bi_ff == 3'h2) ? snap_ff[chan][15:8] :
                        (bi_ff == 3'h3) ? snap_ff[chan][7:0] : sep;
  wire prn_slot = !prn_valid_ff || prn_ready_i;
  wire fire     = (rep_ff == REP_SER) ? fifo_in_ready : ((rep_ff == REP_PRN) && prn_slot);
  wire last_b   = (bi_ff == `SSC_LAST_BYTE) && (pos_ff == n_last);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rep_ff       <= REP_IDLE;
      pos_ff       <= '0;
      bi_ff        <= '0;
      prn_valid_ff <= 1'b0;
      prn_data_ff  <= '0;
    end else if (ce_i) begin
      if (prn_ready_i) prn_valid_ff <= 1'b0;
      case (rep_ff)
        REP_IDLE: if (sample_end) begin
          pos_ff <= '0;
          bi_ff  <= '0;
          if (ser_en) rep_ff <= REP_SER;
          else if (printer_en_i) rep_ff <= REP_PRN;
        end
        REP_SER, REP_PRN: if (fire) begin
          if (rep_ff == REP_PRN) begin
            prn_valid_ff <= 1'b1;
            prn_data_ff  <= cur_byte;
          end
          bi_ff  <= (bi_ff == `SSC_LAST_BYTE) ? 3'h0 : bi_ff + 3'h1;
          pos_ff <= last_b ? 3'h0 : ((bi_ff == `SSC_LAST_BYTE) ? pos_ff + 3'h1 : pos_ff);
          if (last_b) rep_ff <= (rep_ff == REP_SER && printer_en_i) ? REP_PRN : REP_IDLE;
        end
        default: rep_ff <= REP_IDLE;
      endcase
    end
  end
  assign prn_valid_o = prn_valid_ff;
  assign prn_data_o  = prn_data_ff;

  ssc_fifo #(.W(`SSC_FIFO_W), .D(`SSC_FIFO_D)) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (rep_ff == REP_SER),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (cur_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  // Transmitter: 8N1, least significant bit first; idle line is high.
  logic [9:0]  sh_ff;
  logic [3:0]  bits_ff;
  logic [31:0] div_ff, bdiv_ff;
  logic        de_ff, rts_n_ff;
  wire  [3:0]  bsel = (baud_sel_i > `SSC_BAUD_LAST) ? `SSC_BAUD_LAST : baud_sel_i;
  wire  [31:0] bdiv_w = CLK_HZ / BAUD_RATES[bsel];
  wire         tx_idle = (bits_ff == '0);
  // CTS is sampled only between bytes so a frame is never cut short.
  assign fifo_pop = ce_i && tx_idle && fifo_out_valid && (!flow_ctl_i || cts_ok);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sh_ff    <= '1;
      bits_ff  <= '0;
      div_ff   <= '0;
      bdiv_ff  <= '0;
      de_ff    <= 1'b0;
      rts_n_ff <= 1'b1;
    end else if (ce_i) begin
      rts_n_ff <= !flow_ctl_i;
      if (fifo_pop) begin
        sh_ff   <= {1'b1, fifo_out, 1'b0};
        bits_ff <= `SSC_FRAME_BITS;
        bdiv_ff <= bdiv_w;
        div_ff  <= '0;
        de_ff   <= (line_mode_i != `SSC_LINE_RS232);
      end else if (!tx_idle) begin
        if (div_ff == bdiv_ff - 32'h1) begin
          div_ff  <= '0;
          sh_ff   <= {1'b1, sh_ff[9:1]};
          bits_ff <= bits_ff - 4'h1;
          if (bits_ff == 4'h1) de_ff <= 1'b0;
        end else div_ff <= div_ff + 32'h1;
      end
    end
  end
  assign tx_o    = sh_ff[0];
  assign de_o    = de_ff;
  assign rts_n_o = rts_n_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_single_stop: assert property (ce_i && sample_end && mode_ff == `SSC_MODE_SINGLE
    |=> seq_ff == SEQ_STOPPED) else $error("single mode did not stop after one sample");
  chk_repeat_hold: assert property (ce_i && sample_end && mode_ff == `SSC_MODE_REPEAT
    && hold_ff != '0 |=> seq_ff == SEQ_HOLDING && remain_ff == $past(hold_ff))
    else $error("repeat mode did not enter hold");
  chk_count_stop: assert property (ce_i && sample_end && mode_ff == `SSC_MODE_COUNTED
    && done_ff + 14'h1 == ncount_ff |=> seq_ff == SEQ_STOPPED) else $error("count not honoured");
  chk_count_idle: assert property (seq_ff == SEQ_HOLDING && !start_samp
    |=> $stable(cnt_ff[0])) else $error("count changed outside sample");
  chk_short_pump: assert property (seq_ff == SEQ_HOLDING && !long_hold |-> pump_ff)
    else $error("pump off during short hold");
  chk_long_pump: assert property (seq_ff == SEQ_HOLDING && long_hold
    && remain_ff > `SSC_PUMP_LEAD_S |-> !pump_ff) else $error("pump on early in long hold");
  chk_none_fmt: assert property (ce_i && rep_ff == REP_IDLE && sample_end
    && report_fmt_i == `SSC_FMT_NONE |=> rep_ff != REP_SER) else $error("report sent with none");
  chk_alarm_zero: assert property (ce_i && limit_ff[0] == '0 |=> !alarm_ff[0])
    else $error("alarm with zero limit");
  chk_limit_max: assert property (limit_ff[0] <= `SSC_LIMIT_MAX
    && limit_ff[1] <= `SSC_LIMIT_MAX) else $error("alarm limit above maximum");
  chk_cancel_keep: assert property (ce_i && can_edit && cancel_edit_key_i && !edit_open_i
    |=> $stable(limit_ff[0]) && work_ff == limit_ff[$past(tgt_ff)]) else $error("cancel lost value");
  chk_pwd_block: assert property (pwd_set && !unlock_ff |-> !menu_access_o)
    else $error("menu open without password");
  chk_start_key: assert property (ce_i && seq_ff == SEQ_STOPPED && ss_evt
    |=> seq_ff == SEQ_STARTING ##0 status_o == `SSC_ST_STARTING) else $error("start ignored");

  cov_single_run: cover property (seq_ff == SEQ_COUNTING ##1 seq_ff == SEQ_STOPPED);
  cov_hold_entry: cover property (seq_ff == SEQ_COUNTING ##1 seq_ff == SEQ_HOLDING);
  cov_alarm_hit:  cover property (alarm_ff[0]);
  cov_printer:    cover property (prn_valid_o && prn_ready_i);
endmodule // ssc_top

//--- tb/ssc_partner.sv
`timescale 1ns/1ns
module ssc_partner (
  input  wire logic       clk_i,
  input  wire logic       pump_on_i,
  input  wire logic       prn_valid_i,
  output logic      [5:0] particle_o,
  output logic            cts_n_o,
  output logic            prn_ready_o,
  output int              prn_bytes_o
);
  initial begin
    particle_o = 6'h00;
    prn_ready_o = 1'b0;
    prn_bytes_o = 0;
  end
  assign cts_n_o = 1'b0;
  // Air only reaches the sensor while the pump draws it; a slow printer takes every other cycle.
  // Each particle level stands two cycles, so the pin filter sees two agreeing samples.
  always @(negedge clk_i) begin
    particle_o <= pump_on_i ? (particle_o ^ {6{prn_ready_o}}) : 6'h00;
    prn_ready_o <= ~prn_ready_o;
  end
  always @(posedge clk_i) begin
    if (prn_valid_i && prn_ready_o) prn_bytes_o <= prn_bytes_o + 1;
  end
endmodule // ssc_partner

//--- tb/ssc_top_bench.sv
`timescale 1ns/1ns
module ssc_top_bench;
  logic clk = 0, rst = 1, ce = 1, ss = 0, pen = 1, fav = 1, et = 0, eo = 0, ew = 0, cf = 0;
  logic cx = 0, pt = 0, fc = 0, mx = 0, acc, pump, tx, de, rts_n, pvo, cts_n, prdy, txlow = 0;
  logic [1:0] mode = 0, fmt = 0, unit = 0, alarm, status;
  logic [2:0] fs0 = 0, fs1 = 5;
  logic [13:0] cnt = 2, ts = 2, th = 0, pw = 0, pv = 0, remain;
  logic [23:0] ev = 0, lim0, lim1, shown, fv0, fv1;
  logic [5:0] part;
  logic [7:0] pd;
  int errors = 0, checked = 0, nb, n;
  ssc_top #(.TICK_CYCLES(20)) ssc_top_inst (.clk_i(clk), .srst_i(rst), .ce_i(ce),
    .start_stop_i(ss), .particle_i(part), .sample_mode_i(mode), .sample_count_i(cnt),
    .sample_time_i(ts), .hold_time_i(th), .unit_sel_i(unit), .report_fmt_i(fmt),
    .printer_en_i(pen), .baud_sel_i(4'h9), .line_mode_i(2'h0), .addressed_i(1'b0),
    .flow_ctl_i(fc), .cts_n_i(cts_n), .fav_en_i(fav), .fav_sel0_i(fs0), .fav_sel1_i(fs1),
    .edit_open_i(eo), .edit_tgt_i(et), .edit_wr_i(ew), .edit_val_i(ev), .confirm_i(cf),
    .cancel_edit_key_i(cx), .password_i(pw), .pwd_try_i(pt), .pwd_val_i(pv),
    .menu_exit_i(mx), .prn_ready_i(prdy), .menu_access_o(acc), .edit_shown_o(shown),
    .alarm_limit0_o(lim0), .alarm_limit1_o(lim1), .alarm_o(alarm), .status_o(status),
    .remain_s_o(remain), .pump_on_o(pump), .fav_val0_o(fv0), .fav_val1_o(fv1), .tx_o(tx),
    .de_o(de), .rts_n_o(rts_n), .prn_valid_o(pvo), .prn_data_o(pd));
  ssc_partner ssc_partner_inst (.clk_i(clk), .pump_on_i(pump), .prn_valid_i(pvo),
    .particle_o(part), .cts_n_o(cts_n), .prn_ready_o(prdy), .prn_bytes_o(nb));
  always #5 clk = ~clk;
  always @(negedge clk) if (tx === 1'b0) txlow = 1;
  task automatic chk(string s, logic [23:0] seen, logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The pin must stay high and low long enough for the synchroniser to agree.
  task automatic press();
    @(negedge clk) ss = 1;
    repeat (4) @(negedge clk);
    ss = 0;
    repeat (4) @(negedge clk);
  endtask
  task automatic await(logic [1:0] s, logic leave);
    for (n = 0; n < 5000 && ((status === s) == leave); n++) @(negedge clk);
    if (n == 5000) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic edit(logic t, logic [23:0] v, logic keep);
    et = t;
    ev = v;
    @(negedge clk) eo = 1;
    @(negedge clk) eo = 0;
    ew = 1;
    @(negedge clk) ew = 0;
    cf = keep;
    cx = !keep;
    @(negedge clk) cf = 0;
    cx = 0;
    @(negedge clk);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    repeat (2) @(negedge clk);
    chk("status", status, 0);
    chk("pump", pump, 0);
    chk("de", de, 0);
    chk("rts", rts_n, 1);
    fc = 1;
    pw = 5;
    @(negedge clk) chk("locked", acc, 0);
    pv = 5;
    @(negedge clk) pt = 1;
    @(negedge clk) pt = 0;
    @(negedge clk) chk("unlocked", acc, 1);
    chk("rts on", rts_n, 0);
    edit(0, 1, 1);
    chk("limit0", lim0, 1);
    edit(1, 24'hffffff, 1);
    chk("clamp", lim1, 24'h98967f);
    edit(1, 5, 0);
    chk("cancel", lim1, 24'h98967f);
    chk("shown", shown, 24'h98967f);
    edit(1, 0, 1);
    chk("commit", lim1, 0);
    $display("test edit done");
    press();
    await(2, 0);
    chk("remain", remain, 2);
    chk("pump", pump, 1);
    repeat (10) @(negedge clk);
    chk("alarm", alarm, 2'h1);
    await(2, 1);
    chk("single", status, 0);
    for (n = 0; n < 300 && nb != 10; n++) @(negedge clk);
    chk("printed", nb, 10);
    chk("prn sep", pd, 8'h0d);
    chk("no serial", txlow, 0);
    $display("test single done");
    mode = 1;
    th = 2;
    press();
    await(3, 0);
    chk("hold", remain, 2);
    chk("pump", pump, 1);
    await(2, 0);
    press();
    chk("stop", status, 0);
    $display("test repeat done");
    mode = 2;
    th = 65;
    press();
    await(3, 0);
    chk("pump", pump, 0);
    await(2, 0);
    chk("pump", pump, 1);
    await(2, 1);
    chk("counted", status, 0);
    $display("test counted done");
    mx = 1;
    @(negedge clk) mx = 0;
    chk("relock", acc, 0);
    complete_run();
  end
endmodule // ssc_top_bench
